//--- src/bsm_pkg.sv
// shared constants and carrier types for the buck supervisor mode control
package bsm_pkg;

  // --------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned DLY_MS_PER_NF    = 1;
  localparam int unsigned DLY_NF_MIN       = 2;
  localparam int unsigned DLY_NF_MAX       = 200;
  localparam int unsigned DEGLITCH_US      = 20;
  localparam int unsigned DCM_QUAL_US      = 100;
  localparam int unsigned LOAD_PULSE_US    = 100;
  localparam int unsigned MIN_OFF_NS       = 250;
  localparam int unsigned SYNC_TIMEOUT_US  = 32;
  localparam int unsigned SYNC_QUAL_EDGES  = 2;
  localparam int unsigned FSW_MIN_KHZ      = 200;
  localparam int unsigned FSW_MAX_KHZ      = 2200;

  localparam int unsigned DEGLITCH_CYC  = DEGLITCH_US * CLK_MHZ;
  localparam int unsigned DCM_QUAL_CYC  = DCM_QUAL_US * CLK_MHZ;
  localparam int unsigned LOAD_CYC      = LOAD_PULSE_US * CLK_MHZ;
  localparam int unsigned MIN_OFF_CYC   =
    (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_TO_CYC   = SYNC_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned MS_CYC        = 1000 * CLK_MHZ;
  // switching period in cycles at the frequency bounds
  localparam int unsigned PER_MAX_CYC   = (1000 * CLK_MHZ) / FSW_MIN_KHZ;
  localparam int unsigned PER_MIN_CYC   = (1000 * CLK_MHZ) / FSW_MAX_KHZ;

  // --------------------------------------------------------------------
  // register map (word offsets are byte addresses)
  // --------------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL    = 4'h0;
  localparam logic [3:0] OFF_STATUS  = 4'h4;
  localparam logic [3:0] OFF_FSW_PER = 4'h8;
  localparam logic [3:0] OFF_DLY_NF  = 4'hc;

  localparam int unsigned CTRL_ALLOW_BIT = 0;
  localparam logic [11:0] FSW_PER_RST    = 12'd200;
  localparam logic [7:0]  DLY_NF_RST     = 8'd10;
  localparam logic [31:0] UNMAPPED_RDATA = 32'hdead_0000;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic rst_ok;
    logic ov;
    logic discontinuous_conduction;
    logic therm;
    logic en;
    logic lpsel;
    logic sync;
  } bsm_sense_t;

  typedef struct packed {
    logic       switch_on;
    logic       load_on;
    logic       pulse_skip;
    logic       ext_clk;
    logic       softstart_rst;
    logic       por_low;
  } bsm_status_t;

endpackage

//--- src/bsm_top.sv
// control and supervision logic of the step-down regulator
`timescale 1ns/100ps

// Behaviour
// - after output rises above reset threshold, hold reset low 1 ms per nF
// - reset pulled low only after 20 us of output below threshold
// - overvoltage never pulls reset low; it turns the switch off
// - switch stays off while overvoltage is seen
// - pulse-skip entered only after 100 us continuous discontinuous conduction
// - thermal trip disables switch until over-temperature ends
// - output load on for 100 us at power-up and each enable toggle
// - output load on whenever output exceeds overvoltage threshold normally
// - every switching period keeps at least 250 ns off-time
// - internal period settable for 200 kHz to 2200 kHz
// - accepted external sync clock drives the oscillator
// - switch to external clock after two valid sync pulses
// - no sync transition for 32 us reverts to internal oscillator
// - enable rise starts soft-start; enable fall stops switching, resets it
// - low enable means shutdown with regulator disabled
// - reset delay programmable 2 ms to 200 ms
// - reset low until output above threshold and delay expired
// - enable low forces reset low at once
// - after thermal stop, reset low once output below threshold
// - low-power select high forbids low-power operation
// - overvoltage monitoring disabled in low-power operation
// - thermal sensing off in low-power; back on when reset or undervoltage
module bsm_top (
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESETN_IN,
  // comparator and host inputs
  input  wire logic        RESET_THRESHOLD_SENSE_IN,
  input  wire logic        OVERVOLTAGE_SENSE_IN,
  input  wire logic        DISCONTINUOUS_CONDUCTION_IN,
  input  wire logic        THERMAL_TRIP_IN,
  input  wire logic        ENABLE_IN,
  input  wire logic        LOW_POWER_SELECT_IN,
  input  wire logic        SYNC_IN,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  // regulator controls
  output logic             POWER_ON_RESET_N_OUT,
  output logic             POWER_ON_RESET_N_OE_OUT,
  output logic             SWITCH_ON_OUT,
  output logic             OUTPUT_LOAD_ON_OUT,
  output logic             PULSE_SKIP_OPERATION_OUT,
  output logic             SOFTSTART_RESET_OUT,
  output logic             EXT_CLOCK_SELECTED_OUT
);

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  bsm_pkg::bsm_sense_t raw, meta_q, sync_q;
  assign raw = '{rst_ok: RESET_THRESHOLD_SENSE_IN,
                 ov:     OVERVOLTAGE_SENSE_IN,
                 discontinuous_conduction:    DISCONTINUOUS_CONDUCTION_IN,
                 therm:  THERMAL_TRIP_IN,
                 en:     ENABLE_IN,
                 lpsel:  LOW_POWER_SELECT_IN,
                 sync:   SYNC_IN};

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  logic en_prev_q, sync_prev_q;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      en_prev_q   <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      en_prev_q   <= sync_q.en;
      sync_prev_q <= sync_q.sync;
    end
  end
  wire en_toggle  = sync_q.en ^ en_prev_q;
  wire sync_edge  = sync_q.sync ^ sync_prev_q;
  wire sync_rise  = sync_q.sync & ~sync_prev_q;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic        allow_q;
  logic [11:0] fsw_per_q;
  logic [7:0]  dly_nf_q;
  logic        ack_q;

  function automatic logic [11:0] clamp_per(input logic [31:0] v);
    if (v[11:0] < 12'(bsm_pkg::PER_MIN_CYC) || v[31:12] != '0)
      return (v[31:12] != '0) ? 12'(bsm_pkg::PER_MAX_CYC)
                              : 12'(bsm_pkg::PER_MIN_CYC);
    if (v[11:0] > 12'(bsm_pkg::PER_MAX_CYC))
      return 12'(bsm_pkg::PER_MAX_CYC);
    return v[11:0];
  endfunction

  function automatic logic [7:0] clamp_nf(input logic [31:0] v);
    if (v[31:8] != '0 || v[7:0] > 8'(bsm_pkg::DLY_NF_MAX))
      return 8'(bsm_pkg::DLY_NF_MAX);
    if (v[7:0] < 8'(bsm_pkg::DLY_NF_MIN))
      return 8'(bsm_pkg::DLY_NF_MIN);
    return v[7:0];
  endfunction

  // one wait state per access
  wire req = AVS_READ_IN | AVS_WRITE_IN;
  assign AVS_WAITREQUEST_OUT = req & ~ack_q;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) ack_q <= 1'b0;
    else            ack_q <= req & ~ack_q;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      allow_q   <= 1'b1;
      fsw_per_q <= bsm_pkg::FSW_PER_RST;
      dly_nf_q  <= bsm_pkg::DLY_NF_RST;
    end else if (AVS_WRITE_IN && ack_q) begin
      case (AVS_ADDRESS_IN)
        bsm_pkg::OFF_CTRL:
          allow_q <= AVS_WRITEDATA_IN[bsm_pkg::CTRL_ALLOW_BIT];
        bsm_pkg::OFF_FSW_PER: fsw_per_q <= clamp_per(AVS_WRITEDATA_IN);
        bsm_pkg::OFF_DLY_NF:  dly_nf_q  <= clamp_nf(AVS_WRITEDATA_IN);
        default: ;
      endcase
    end
  end

  bsm_pkg::bsm_status_t st;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      AVS_READDATA_OUT <= '0;
    end else if (AVS_READ_IN && !ack_q) begin
      case (AVS_ADDRESS_IN)
        bsm_pkg::OFF_CTRL:    AVS_READDATA_OUT <= {31'h0, allow_q};
        bsm_pkg::OFF_STATUS:  AVS_READDATA_OUT <= {26'h0, st};
        bsm_pkg::OFF_FSW_PER: AVS_READDATA_OUT <= {20'h0, fsw_per_q};
        bsm_pkg::OFF_DLY_NF:  AVS_READDATA_OUT <= {24'h0, dly_nf_q};
        default:              AVS_READDATA_OUT <= bsm_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // low-power mode and sensing gates
  // --------------------------------------------------------------------
  logic [13:0] dcm_cnt_q;
  logic        pskip_q;
  logic        por_low_q;
  logic        reset_n_q;
  wire         enabled = sync_q.en & allow_q;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      dcm_cnt_q <= '0;
      pskip_q   <= 1'b0;
    end else if (!enabled || sync_q.lpsel || !sync_q.discontinuous_conduction ||
                 !reset_n_q || !sync_q.rst_ok) begin
      dcm_cnt_q <= '0;
      pskip_q   <= 1'b0;
    end else if (dcm_cnt_q >= 14'(bsm_pkg::DCM_QUAL_CYC - 1)) begin
      pskip_q   <= 1'b1;
    end else begin
      dcm_cnt_q <= dcm_cnt_q + 14'd1;
    end
  end

  wire ov_act  = sync_q.ov & ~pskip_q;
  // thermal sensing off in low power
  wire th_act  = sync_q.therm & ~pskip_q;

  // --------------------------------------------------------------------
  // enable, soft-start and switch permission
  // --------------------------------------------------------------------
  logic thermal_stop_q;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) thermal_stop_q <= 1'b0;
    else            thermal_stop_q <= th_act;
  end

  wire run = enabled & ~thermal_stop_q;
  wire switch_allow = run & ~ov_act;

  // --------------------------------------------------------------------
  // output load timer
  // --------------------------------------------------------------------
  logic [13:0] load_cnt_q;
  logic        pwr_up_q;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      load_cnt_q <= '0;
      pwr_up_q   <= 1'b1;
    end else begin
      pwr_up_q <= 1'b0;
      if (pwr_up_q || en_toggle)
        load_cnt_q <= 14'(bsm_pkg::LOAD_CYC);
      else if (load_cnt_q != '0)
        load_cnt_q <= load_cnt_q - 14'd1;
    end
  end

  // --------------------------------------------------------------------
  // sync qualification and timeout
  // --------------------------------------------------------------------
  logic [1:0]  sync_pulses_q;
  logic [11:0] sync_to_q;
  logic        ext_q;
  logic        ext_tick;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync_pulses_q <= '0;
      sync_to_q     <= '0;
      ext_q         <= 1'b0;
    end else if (sync_edge) begin
      sync_to_q <= '0;
      if (sync_rise && !ext_q) begin
        if (sync_pulses_q == 2'(bsm_pkg::SYNC_QUAL_EDGES - 1))
          ext_q <= 1'b1;
        else
          sync_pulses_q <= sync_pulses_q + 2'd1;
      end
    end else if (sync_to_q >= 12'(bsm_pkg::SYNC_TO_CYC - 1)) begin
      ext_q         <= 1'b0;
      sync_pulses_q <= '0;
    end else begin
      sync_to_q <= sync_to_q + 12'd1;
    end
  end
  // relies on host sync in range
  assign ext_tick = ext_q & sync_rise;

  // last sync period less one; sets the on-time in external mode
  logic [11:0] sync_cnt_q;
  logic [11:0] sync_per_q;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync_cnt_q <= '0;
      sync_per_q <= '0;
    end else if (sync_rise) begin
      sync_cnt_q <= '0;
      sync_per_q <= sync_cnt_q;
    end else if (sync_cnt_q != 12'hfff) begin
      sync_cnt_q <= sync_cnt_q + 12'd1;
    end
  end

  // --------------------------------------------------------------------
  // switching period generator
  // --------------------------------------------------------------------
  logic [11:0] per_cnt_q;
  logic        on_q;
  // a fixed internal limit would leave no off time at a faster sync
  wire  [11:0] on_limit = ext_q ? sync_per_q - 12'(bsm_pkg::MIN_OFF_CYC - 1)
                                : fsw_per_q - 12'(bsm_pkg::MIN_OFF_CYC);
  wire         int_wrap = per_cnt_q >= fsw_per_q - 12'd1;
  wire         new_cyc  = ext_q ? ext_tick : int_wrap;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) per_cnt_q <= '0;
    else if (new_cyc || !run) per_cnt_q <= '0;
    else if (per_cnt_q != 12'hfff) per_cnt_q <= per_cnt_q + 12'd1;
  end

  // off cycles so far; a clock switch-over may start a cycle early
  logic [5:0] off_cnt_q;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) off_cnt_q <= '0;
    else if (on_q) off_cnt_q <= '0;
    else if (off_cnt_q != 6'h3f) off_cnt_q <= off_cnt_q + 6'd1;
  end
  wire off_done = off_cnt_q >= 6'(bsm_pkg::MIN_OFF_CYC - 1);

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) on_q <= 1'b0;
    else if (!switch_allow) on_q <= 1'b0;
    else if (new_cyc && off_done) on_q <= 1'b1;
    else if (per_cnt_q >= on_limit - 12'd1) on_q <= 1'b0;
  end

  // --------------------------------------------------------------------
  // power-on reset supervisor
  // --------------------------------------------------------------------
  logic [11:0] dg_cnt_q;
  logic [16:0] ms_cnt_q;
  logic [7:0]  ms_left_q;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      reset_n_q <= 1'b0;
      dg_cnt_q  <= '0;
      ms_cnt_q  <= '0;
      ms_left_q <= '0;
    end else if (!enabled) begin
      reset_n_q <= 1'b0;
      dg_cnt_q  <= '0;
      ms_cnt_q  <= '0;
      ms_left_q <= dly_nf_q;
    end else if (reset_n_q) begin
      if (sync_q.rst_ok) dg_cnt_q <= '0;
      else if (dg_cnt_q >= 12'(bsm_pkg::DEGLITCH_CYC - 1)) begin
        reset_n_q <= 1'b0;
        ms_left_q <= dly_nf_q;
        dg_cnt_q  <= '0;
      end else dg_cnt_q <= dg_cnt_q + 12'd1;
    end else if (!sync_q.rst_ok) begin
      ms_cnt_q  <= '0;
      ms_left_q <= dly_nf_q;
    end else if (ms_left_q == '0) begin
      reset_n_q <= 1'b1;
    end else if (ms_cnt_q >= 17'(bsm_pkg::MS_CYC - 1)) begin
      ms_cnt_q  <= '0;
      ms_left_q <= ms_left_q - 8'(bsm_pkg::DLY_MS_PER_NF);
    end else begin
      ms_cnt_q <= ms_cnt_q + 17'd1;
    end
  end
  assign por_low_q = ~reset_n_q;

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // open drain, low only
  assign POWER_ON_RESET_N_OUT     = 1'b0;
  assign POWER_ON_RESET_N_OE_OUT  = por_low_q;
  assign SWITCH_ON_OUT            = on_q;
  assign OUTPUT_LOAD_ON_OUT       = (load_cnt_q != '0) | (ov_act & enabled);
  assign PULSE_SKIP_OPERATION_OUT = pskip_q;
  assign SOFTSTART_RESET_OUT      = ~run;
  assign EXT_CLOCK_SELECTED_OUT   = ext_q;

  assign st = '{switch_on:     on_q,
                load_on:       OUTPUT_LOAD_ON_OUT,
                pulse_skip:    pskip_q,
                ext_clk:       ext_q,
                softstart_rst: ~run,
                por_low:       por_low_q};

endmodule

//--- dv/bsm_host_model.sv
// host model driving enable, low-power select and sync
`timescale 1ns/100ps
module bsm_host_model (
  // clock and commands
  input  wire logic        clk_in,
  input  wire logic        en_cmd_in,
  input  wire logic        lp_cmd_in,
  input  wire logic [15:0] half_in,
  // pins toward the regulator
  output logic             en_out,
  output logic             lpsel_out,
  output logic             sync_out
);
  int cnt_q;
  initial begin
    en_out = 1'b0;
    lpsel_out = 1'b0;
    sync_out = 1'b0;
    cnt_q = 0;
  end
  always @(posedge clk_in) begin
    en_out <= en_cmd_in;
    lpsel_out <= lp_cmd_in;
    if (half_in == 16'h0000) begin
      // stopped sync rests at its pull-down level
      sync_out <= 1'b0;
      cnt_q <= 0;
    end else if (cnt_q + 1 >= int'(half_in)) begin
      sync_out <= !sync_out;
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

//--- dv/bsm_monitor.sv
// bound checker for the regulator control ports
`timescale 1ns/100ps
module bsm_monitor (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // sense and host inputs
  input wire logic RESET_THRESHOLD_SENSE_IN,
  input wire logic OVERVOLTAGE_SENSE_IN,
  input wire logic DISCONTINUOUS_CONDUCTION_IN,
  input wire logic THERMAL_TRIP_IN,
  input wire logic ENABLE_IN,
  input wire logic LOW_POWER_SELECT_IN,
  input wire logic SYNC_IN,
  // regulator controls
  input wire logic POWER_ON_RESET_N_OUT,
  input wire logic POWER_ON_RESET_N_OE_OUT,
  input wire logic SWITCH_ON_OUT,
  input wire logic OUTPUT_LOAD_ON_OUT,
  input wire logic PULSE_SKIP_OPERATION_OUT,
  input wire logic SOFTSTART_RESET_OUT,
  input wire logic EXT_CLOCK_SELECTED_OUT
);
  localparam int DLY_MIN = bsm_pkg::DLY_NF_MIN * bsm_pkg::MS_CYC;
  localparam int SYNC_TO = bsm_pkg::SYNC_TO_CYC;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // --------------------------------------------------------------------
  // run lengths on raw pins
  // --------------------------------------------------------------------
  // raw counts lead the synchronised ones, so lower bounds stay safe
  int   lo_q, hi_q, en_q, dcm_q, off_q, idle_q, rise_q;
  logic sync_q;
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lo_q <= 0;
      hi_q <= 0;
      en_q <= 0;
      dcm_q <= 0;
      off_q <= 1000;
      idle_q <= 0;
      rise_q <= 0;
      sync_q <= 1'b0;
    end else begin
      lo_q <= RESET_THRESHOLD_SENSE_IN ? 0 : lo_q + 1;
      hi_q <= (RESET_THRESHOLD_SENSE_IN && ENABLE_IN) ? hi_q + 1 : 0;
      en_q <= ENABLE_IN ? en_q + 1 : 0;
      dcm_q <= DISCONTINUOUS_CONDUCTION_IN ? dcm_q + 1 : 0;
      off_q <= SWITCH_ON_OUT ? 0 : off_q + 1;
      idle_q <= (SYNC_IN != sync_q) ? 0 : idle_q + 1;
      rise_q <= (SYNC_IN && !sync_q) ? rise_q + 1 :
                (idle_q > SYNC_TO) ? 0 : rise_q;
      sync_q <= SYNC_IN;
    end
  end
  sequence s_en_low; !ENABLE_IN [*5]; endsequence
  sequence s_ov_held;
    (OVERVOLTAGE_SENSE_IN && ENABLE_IN && !PULSE_SKIP_OPERATION_OUT) [*4];
  endsequence
  sequence s_uv; !RESET_THRESHOLD_SENSE_IN [*4]; endsequence
  property p_od; POWER_ON_RESET_N_OUT == 1'b0; endproperty
  property p_release; $fell(POWER_ON_RESET_N_OE_OUT) |-> hi_q >= DLY_MIN;
  endproperty
  property p_deglitch; $rose(POWER_ON_RESET_N_OE_OUT) && en_q > 8 |->
    lo_q >= bsm_pkg::DEGLITCH_CYC; endproperty
  property p_en_low; s_en_low |-> POWER_ON_RESET_N_OE_OUT &&
    SOFTSTART_RESET_OUT && !SWITCH_ON_OUT; endproperty
  property p_ov_sw; s_ov_held |-> !SWITCH_ON_OUT; endproperty
  property p_ov_load; s_ov_held |-> OUTPUT_LOAD_ON_OUT; endproperty
  property p_therm; (THERMAL_TRIP_IN && !PULSE_SKIP_OPERATION_OUT) [*5]
    |-> !SWITCH_ON_OUT; endproperty
  property p_off; $rose(SWITCH_ON_OUT) |-> off_q >= bsm_pkg::MIN_OFF_CYC;
  endproperty
  property p_pskip; $rose(PULSE_SKIP_OPERATION_OUT) |->
    dcm_q >= bsm_pkg::DCM_QUAL_CYC && !LOW_POWER_SELECT_IN; endproperty
  property p_lp_exit; s_uv |-> !PULSE_SKIP_OPERATION_OUT; endproperty
  property p_accept; $rose(EXT_CLOCK_SELECTED_OUT) |-> rise_q >= 2;
  endproperty
  property p_revert; idle_q > SYNC_TO + 4 |-> !EXT_CLOCK_SELECTED_OUT;
  endproperty
  property p_load_tgl; $changed(ENABLE_IN) |-> ##[1:4] OUTPUT_LOAD_ON_OUT;
  endproperty
  a_od: assert property (p_od)
    else $error("reset pin driven high");
  a_release: assert property (p_release)
    else $error("reset released early");
  a_deglitch: assert property (p_deglitch)
    else $error("reset asserted before filter time");
  a_en_low: assert property (p_en_low)
    else $error("enable low not honoured");
  a_ov_sw: assert property (p_ov_sw)
    else $error("switch on during overvoltage");
  a_ov_load: assert property (p_ov_load)
    else $error("load off during overvoltage");
  a_therm: assert property (p_therm)
    else $error("switch on during thermal trip");
  a_off: assert property (p_off)
    else $error("off time too short");
  a_pskip: assert property (p_pskip)
    else $error("pulse skip entered early");
  a_lp_exit: assert property (p_lp_exit)
    else $error("low power kept under undervoltage");
  a_accept: assert property (p_accept)
    else $error("sync taken before two pulses");
  a_revert: assert property (p_revert)
    else $error("sync kept after timeout");
  a_load_tgl: assert property (p_load_tgl)
    else $error("no load pulse on enable toggle");
endmodule
bind bsm_top bsm_monitor u_mon (.REF_CLK_IN(REF_CLK_IN),
  .RESETN_IN(RESETN_IN), .RESET_THRESHOLD_SENSE_IN(RESET_THRESHOLD_SENSE_IN),
  .OVERVOLTAGE_SENSE_IN(OVERVOLTAGE_SENSE_IN), .ENABLE_IN(ENABLE_IN),
  .DISCONTINUOUS_CONDUCTION_IN(DISCONTINUOUS_CONDUCTION_IN),
  .THERMAL_TRIP_IN(THERMAL_TRIP_IN), .SYNC_IN(SYNC_IN),
  .LOW_POWER_SELECT_IN(LOW_POWER_SELECT_IN), .SWITCH_ON_OUT(SWITCH_ON_OUT),
  .POWER_ON_RESET_N_OUT(POWER_ON_RESET_N_OUT),
  .POWER_ON_RESET_N_OE_OUT(POWER_ON_RESET_N_OE_OUT),
  .OUTPUT_LOAD_ON_OUT(OUTPUT_LOAD_ON_OUT),
  .PULSE_SKIP_OPERATION_OUT(PULSE_SKIP_OPERATION_OUT),
  .SOFTSTART_RESET_OUT(SOFTSTART_RESET_OUT),
  .EXT_CLOCK_SELECTED_OUT(EXT_CLOCK_SELECTED_OUT));

//--- dv/tb.sv
// self-checking bench for the regulator control block
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0, rstn = 1'b0, rok = 1'b0, ov = 1'b0;
  logic        discontinuous_conduction = 1'b0, th = 1'b0, en_c = 1'b0, lp_c = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, en, lp, sy, wq, por, oe, sw, ld, ps;
  logic        ss, ex;
  logic [15:0] half = 16'h0000;
  logic [3:0]  ad = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdat, q;
  int          miscompares = 0, n_checks = 0, cyc = 0, t0, c, per, h, d;
  int          dv[$] = '{10, 1000, 0, 0, 255, 2};
  logic [31:0] m[4] = '{32'h1, 32'h13, 32'hc8, 32'ha};
  always #(bsm_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  bsm_host_model host (.clk_in(clk), .en_cmd_in(en_c), .lp_cmd_in(lp_c),
    .half_in(half), .en_out(en), .lpsel_out(lp), .sync_out(sy));
  bsm_top uut (.REF_CLK_IN(clk), .RESETN_IN(rstn),
    .RESET_THRESHOLD_SENSE_IN(rok), .OVERVOLTAGE_SENSE_IN(ov),
    .DISCONTINUOUS_CONDUCTION_IN(discontinuous_conduction), .THERMAL_TRIP_IN(th),
    .ENABLE_IN(en), .LOW_POWER_SELECT_IN(lp), .SYNC_IN(sy),
    .AVS_ADDRESS_IN(ad), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wq), .POWER_ON_RESET_N_OUT(por),
    .POWER_ON_RESET_N_OE_OUT(oe), .SWITCH_ON_OUT(sw),
    .OUTPUT_LOAD_ON_OUT(ld), .PULSE_SKIP_OPERATION_OUT(ps),
    .SOFTSTART_RESET_OUT(ss), .EXT_CLOCK_SELECTED_OUT(ex));
  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int v, lo, hi);
    chk(nm, {31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask
  // waits for the slave; only the watchdog bounds the wait
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] dat);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= dat;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic sg(input int s);
    case (s)
      0: return sw;
      1: return oe;
      2: return ex;
      3: return ps;
      4: return ld;
      5: return en;
      default: return sy;
    endcase
  endfunction
  task automatic wfor(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (sg(s) !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic prd(output int p);
    wfor(0, 1'b0, 1000);
    wfor(0, 1'b1, 1000);
    p = cyc;
    wfor(0, 1'b0, 1000);
    wfor(0, 1'b1, 1000);
    p = cyc - p;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (320000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(17693));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(4 * i), 32'h0);
      chk("reg_reset", i == 1 ? q & 32'h3f : q, m[i]);
    end
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, bsm_pkg::UNMAPPED_RDATA);
    // period 100..500 keeps a 0.75 ratio sync inside both limits
    per = 100 + $urandom % 401;
    dv[2] = per;
    foreach (dv[i]) begin
      c = i < 3 ? bsm_pkg::PER_MIN_CYC : bsm_pkg::DLY_NF_MIN;
      d = i < 3 ? bsm_pkg::PER_MAX_CYC : bsm_pkg::DLY_NF_MAX;
      bus(1'b1, i < 3 ? bsm_pkg::OFF_FSW_PER : bsm_pkg::OFF_DLY_NF, dv[i]);
      bus(1'b0, i < 3 ? bsm_pkg::OFF_FSW_PER : bsm_pkg::OFF_DLY_NF, 32'h0);
      chk("clamp", q, dv[i] < c ? c : dv[i] > d ? d : dv[i]);
    end
    wfor(4, 1'b0, 20000);
    rng("power_up_load", cyc, bsm_pkg::LOAD_CYC, bsm_pkg::LOAD_CYC + 8);
    $display("test registers and power-up done");
    @(posedge clk) rok <= 1'b1;
    en_c <= 1'b1;
    wfor(5, 1'b1, 10);
    t0 = cyc;
    wt(8);
    chk("enable_load", ld, 1'b1);
    chk("softstart", ss, 1'b0);
    wfor(1, 1'b0, 210000);
    d = 2 * bsm_pkg::MS_CYC * bsm_pkg::DLY_MS_PER_NF;
    rng("release", cyc - t0, d, d + 8);
    prd(c);
    chk("period", c, per);
    $display("test release and period done");
    h = per * 3 / 8;
    @(posedge clk) half <= 16'(h);
    wfor(6, 1'b1, 1000);
    wt(6);
    chk("ext_one_pulse", ex, 1'b0);
    wfor(6, 1'b0, 1000);
    wfor(6, 1'b1, 1000);
    wt(6);
    chk("ext_two_pulse", ex, 1'b1);
    prd(c);
    chk("sync_period", c, 2 * h);
    wfor(6, 1'b1, 1000);
    wfor(6, 1'b0, 1000);
    t0 = cyc;
    @(posedge clk) half <= 16'h0000;
    wfor(2, 1'b0, 5000);
    d = bsm_pkg::SYNC_TO_CYC;
    rng("revert", cyc - t0, d, d + 8);
    $display("test sync done");
    @(posedge clk) ov <= 1'b1;
    wt(8);
    chk("ov_load", ld, 1'b1);
    wfor(0, 1'b1, 600);
    chk("ov_switch", sw, 1'b0);
    chk("ov_no_reset", oe, 1'b0);
    @(posedge clk) ov <= 1'b0;
    rok <= 1'b0;
    wt(1 + $urandom % 1900);
    @(posedge clk) rok <= 1'b1;
    wt(8);
    chk("glitch", oe, 1'b0);
    $display("test overvoltage and glitch done");
    @(posedge clk) lp_c <= 1'b1;
    discontinuous_conduction <= 1'b1;
    wt(bsm_pkg::DCM_QUAL_CYC + 500);
    chk("lpsel_forbid", ps, 1'b0);
    @(posedge clk) discontinuous_conduction <= 1'b0;
    lp_c <= 1'b0;
    wt(8);
    @(posedge clk) discontinuous_conduction <= 1'b1;
    t0 = cyc;
    wfor(3, 1'b1, 20000);
    d = bsm_pkg::DCM_QUAL_CYC;
    rng("pskip_entry", cyc - t0, d, d + 8);
    @(posedge clk) ov <= 1'b1;
    wt(8);
    chk("lp_ov_load", ld, 1'b0);
    @(posedge clk) ov <= 1'b0;
    rok <= 1'b0;
    t0 = cyc;
    wt(8);
    chk("lp_exit", ps, 1'b0);
    wfor(1, 1'b1, 3000);
    d = bsm_pkg::DEGLITCH_CYC;
    rng("deglitch", cyc - t0, d, d + 8);
    $display("test low power done");
    @(posedge clk) th <= 1'b1;
    wt(8);
    wfor(0, 1'b1, 600);
    chk("therm_off", sw, 1'b0);
    @(posedge clk) th <= 1'b0;
    wfor(0, 1'b1, 600);
    chk("therm_resume", sw, 1'b1);
    @(posedge clk) en_c <= 1'b0;
    wfor(5, 1'b0, 10);
    wt(5);
    chk("en_low_reset", oe, 1'b1);
    chk("en_low_ss", ss, 1'b1);
    chk("en_low_sw", sw, 1'b0);
    chk("en_low_load", ld, 1'b1);
    $display("test thermal and shutdown done");
    summarize();
  end
endmodule
